// ==== core/fts_consts.svh ====
// Register offsets, reset values and timing counts of the fan tach block
`ifndef FTS_CONSTS_SVH
`define FTS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FTS_ADDR_LOCAL_TEMP      8'h00
`define FTS_ADDR_LOCAL_HIGH      8'h05
`define FTS_ADDR_CNT_LOW         8'h46
`define FTS_ADDR_CNT_HIGH        8'h47
`define FTS_ADDR_LIM_LOW         8'h48
`define FTS_ADDR_LIM_HIGH        8'h49

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FTS_RST_LOCAL_HIGH       8'h46
`define FTS_RST_LIM_HIGH         8'hFF
`define FTS_RST_LIM_LOW6         6'h3F
`define FTS_RST_BYTE             8'h00
`define FTS_CNT_FULL             16'hFFFF

// ----------------------------------------------------------------------
// Edge-count setting codes
// ----------------------------------------------------------------------
`define FTS_SEL_RSVD             2'h0
`define FTS_SEL_2E_X4            2'h1
`define FTS_SEL_2E_X2            2'h2
`define FTS_SEL_5E_X1            2'h3

// ----------------------------------------------------------------------
// Timebase: system clock and tach timebase, in Hz
// ----------------------------------------------------------------------
`define FTS_SYS_CLK_HZ           250000000
`define FTS_TB_HZ                360000
`define FTS_TB_DIV               (`FTS_SYS_CLK_HZ / `FTS_TB_HZ)

`endif

// ==== core/fts_pkg.sv ====
// Types shared by the fan tach block
package fts_pkg;

    // Period measurement states
    typedef enum logic {
        FTS_WAIT_FIRST,
        FTS_MEASURE
    } fts_tach_state_type;

endpackage

// ==== core/fts_tach_meas.sv ====
// Fan tach period measurement with saturating count
`timescale 1ns/1ps
`include "fts_consts.svh"

module fts_tach_meas
    import fts_pkg::*;
#(
    parameter int unsigned DIV = `FTS_TB_DIV  // Sys cycles per timebase tick
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        tach_i,
    input  wire logic [1:0]  edge_sel_i,
    output logic      [15:0] period_o,
    output logic             period_upd_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [15:0]        div_r;        // Timebase divider
    logic               tick_r;       // One-cycle timebase enable
    logic               tach_s1_r;    // Sync stage one, read by s2 only
    logic               tach_s2_r;    // Sync stage two
    logic               tach_d_r;     // Delayed copy for edge detect
    logic               rise;         // Rising tach edge
    logic [15:0]        acc_r;        // Period accumulator
    logic [2:0]         left_r;       // Edges still to see
    logic [2:0]         need_m1;      // Edges per measurement minus one
    logic [2:0]         mult;         // Count added per tick
    logic [16:0]        sum;          // Wide sum to spot overflow
    fts_tach_state_type state_r;      // Measurement state

    // ------------------------------------------------------------------
    // Timebase divider
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_r  <= 16'h0000;
            tick_r <= 1'b0;
        end else if (div_r == 16'(DIV - 1)) begin
            div_r  <= 16'h0000;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Tach pin synchroniser and edge detect
    // ------------------------------------------------------------------
    // Stages reset to the pulled-up idle level, so that releasing reset
    // with the pin high never shows up as a false rising edge
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tach_s1_r <= 1'b1;
            tach_s2_r <= 1'b1;
            tach_d_r  <= 1'b1;
        end else begin
            tach_s1_r <= tach_i;
            tach_s2_r <= tach_s1_r;
            tach_d_r  <= tach_s2_r;
        end
    end

    assign rise = tach_s2_r & ~tach_d_r;

    // ------------------------------------------------------------------
    // Setting decode; reserved code behaves like five edges, times one
    // ------------------------------------------------------------------
    always_comb begin
        case (edge_sel_i)
            `FTS_SEL_2E_X4: begin
                need_m1 = 3'h1;
                mult    = 3'h4;
            end
            `FTS_SEL_2E_X2: begin
                need_m1 = 3'h1;
                mult    = 3'h2;
            end
            default: begin
                need_m1 = 3'h4;
                mult    = 3'h1;
            end
        endcase
    end

    assign sum = {1'b0, acc_r} + {14'h0000, mult};

    // ------------------------------------------------------------------
    // Measurement: edge wins over a tick in the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r      <= FTS_WAIT_FIRST;
            acc_r        <= 16'h0000;
            left_r       <= 3'h0;
            period_o     <= `FTS_CNT_FULL;
            period_upd_o <= 1'b0;
        end else begin
            period_upd_o <= 1'b0;
            case (state_r)
                FTS_WAIT_FIRST: begin
                    if (rise) begin
                        acc_r   <= 16'h0000;
                        left_r  <= need_m1;
                        state_r <= FTS_MEASURE;
                    end
                end
                FTS_MEASURE: begin
                    if (rise) begin
                        if (left_r <= 3'h1) begin
                            period_o     <= acc_r;
                            period_upd_o <= 1'b1;
                            acc_r        <= 16'h0000;
                            left_r       <= need_m1;
                        end else begin
                            left_r <= left_r - 3'h1;
                        end
                    end else if (tick_r && acc_r != `FTS_CNT_FULL) begin
                        if (sum[16]) begin
                            // Stalled fan: pin at full scale, no wrap
                            acc_r        <= `FTS_CNT_FULL;
                            period_o     <= `FTS_CNT_FULL;
                            period_upd_o <= 1'b1;
                        end else begin
                            acc_r <= sum[15:0];
                        end
                    end
                end
                default: state_r <= FTS_WAIT_FIRST;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_sat_hold;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (acc_r == `FTS_CNT_FULL && !rise) |=> (acc_r == `FTS_CNT_FULL);
    endproperty
    a_sat_hold: assert property (p_sat_hold)
        else $error("Saturated period count moved without an edge");

    property p_sat_pub;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state_r == FTS_MEASURE && tick_r && !rise && sum[16]
            && acc_r != `FTS_CNT_FULL)
            |=> (period_o == `FTS_CNT_FULL && period_upd_o);
    endproperty
    a_sat_pub: assert property (p_sat_pub)
        else $error("Overflow did not publish full-scale period");

    c_sat: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(acc_r == `FTS_CNT_FULL));

endmodule // fts_tach_meas

// ==== core/fts_top.sv ====
// Fan tach count, tach limit and local temperature registers
// How it works
// - Read-only 16-bit tach period count, two bytes
// - High byte at higher address, low lower
// - Low count bits 1:0 report edge setting
// - Local temperature read-only at address 00
// - Writable local high limit, resets 0x46
`timescale 1ns/1ps
`include "fts_consts.svh"

module fts_top
    import fts_pkg::*;
#(
    parameter int unsigned TB_DIV = `FTS_TB_DIV  // Cycles per 360 kHz tick
) (
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        tach_i,          // Fan tach pin
    input  wire logic [1:0]  edge_sel_i,      // Edge-count setting
    input  wire logic [7:0]  temp_local_i,    // Converted die temperature
    input  wire logic        temp_valid_i,    // New die temperature
    input  wire logic [7:0]  reg_addr_i,      // Register address
    input  wire logic        reg_wr_i,        // Write strobe
    input  wire logic [7:0]  reg_wdata_i,     // Write data
    input  wire logic        reg_rd_i,        // Read strobe
    output logic      [7:0]  reg_rdata_o,     // Read data, one cycle later
    output logic      [7:0]  local_high_o,    // Local high limit
    output logic      [15:0] tach_limit_o     // Tach limit, bits 1:0 zero
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic        rst_meta_r;    // Reset sync stage one
    logic        rst_n_r;       // Released reset for the design
    logic [15:0] period;        // Measured period from the meter
    logic        period_upd;    // New period pulse
    logic [15:0] count_r;       // Latest count
    logic [7:0]  shadow_r;      // High byte locked by low read
    logic [7:0]  temp_r;        // Die temperature
    logic [7:0]  rd_mux;        // Read data before the flop
    logic [7:0]  cnt_low;       // Low count byte as read

    // ------------------------------------------------------------------
    // Reset release through two flops
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Period meter
    // ------------------------------------------------------------------
    fts_tach_meas #(
        .DIV (TB_DIV)
    ) u_meas (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_r),
        .tach_i       (tach_i),
        .edge_sel_i   (edge_sel_i),
        .period_o     (period),
        .period_upd_o (period_upd)
    );

    // ------------------------------------------------------------------
    // Count capture; starts at full scale like a stalled fan in settings 01 and 10
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            count_r <= `FTS_CNT_FULL;
        end else if (period_upd) begin
            count_r <= period;
        end
    end

    // Low byte carries the edge setting in bits 1:0
    assign cnt_low = {count_r[7:2], edge_sel_i};

    // ------------------------------------------------------------------
    // High byte lock on low byte read
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            shadow_r <= `FTS_RST_LIM_HIGH;
        end else if (reg_rd_i && reg_addr_i == `FTS_ADDR_CNT_LOW) begin
            shadow_r <= count_r[15:8];
        end
    end

    // ------------------------------------------------------------------
    // Die temperature capture
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            temp_r <= `FTS_RST_BYTE;
        end else if (temp_valid_i) begin
            temp_r <= temp_local_i;
        end
    end

    // ------------------------------------------------------------------
    // Writable limits
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            local_high_o <= `FTS_RST_LOCAL_HIGH;
            tach_limit_o <= {`FTS_RST_LIM_HIGH, `FTS_RST_LIM_LOW6, 2'h0};
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `FTS_ADDR_LOCAL_HIGH: local_high_o <= reg_wdata_i;
                // Limit bits 1:0 are unused and stay zero
                `FTS_ADDR_LIM_LOW:
                    tach_limit_o[7:0]  <= {reg_wdata_i[7:2], 2'h0};
                `FTS_ADDR_LIM_HIGH:
                    tach_limit_o[15:8] <= reg_wdata_i;
                default: ;  // Read-only and unmapped writes ignored
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read mux; unmapped addresses read zero
    // ------------------------------------------------------------------
    always_comb begin
        case (reg_addr_i)
            `FTS_ADDR_LOCAL_TEMP: rd_mux = temp_r;
            `FTS_ADDR_LOCAL_HIGH: rd_mux = local_high_o;
            `FTS_ADDR_CNT_LOW:    rd_mux = cnt_low;
            `FTS_ADDR_CNT_HIGH:   rd_mux = shadow_r;
            `FTS_ADDR_LIM_LOW:    rd_mux = tach_limit_o[7:0];
            `FTS_ADDR_LIM_HIGH:   rd_mux = tach_limit_o[15:8];
            default:              rd_mux = `FTS_RST_BYTE;
        endcase
    end

    // Read data held until the next read
    always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reg_rdata_o <= `FTS_RST_BYTE;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_cnt_low;
        @(posedge sys_clk_i) disable iff (!rst_n_r)
        (reg_rd_i && reg_addr_i == `FTS_ADDR_CNT_LOW)
            |=> (reg_rdata_o[7:2] == $past(count_r[7:2]));
    endproperty
    a_cnt_low: assert property (p_cnt_low)
        else $error("Low count byte read wrong");

    property p_lock;
        @(posedge sys_clk_i) disable iff (!rst_n_r)
        (reg_rd_i && reg_addr_i == `FTS_ADDR_CNT_LOW)
            ##1 (reg_rd_i && reg_addr_i == `FTS_ADDR_CNT_HIGH)
            |=> (reg_rdata_o == $past(count_r[15:8], 2));
    endproperty
    a_lock: assert property (p_lock)
        else $error("High byte not from same measurement as low byte");

    property p_high_addr;
        @(posedge sys_clk_i) disable iff (!rst_n_r)
        (reg_rd_i && reg_addr_i == `FTS_ADDR_CNT_HIGH)
            |=> (reg_rdata_o == $past(shadow_r));
    endproperty
    a_high_addr: assert property (p_high_addr)
        else $error("High count byte not at higher address");

    property p_sel_bits;
        @(posedge sys_clk_i) disable iff (!rst_n_r)
        (reg_rd_i && reg_addr_i == `FTS_ADDR_CNT_LOW)
            |=> (reg_rdata_o[1:0] == $past(edge_sel_i));
    endproperty
    a_sel_bits: assert property (p_sel_bits)
        else $error("Edge setting bits wrong in low count byte");

    property p_temp;
        @(posedge sys_clk_i) disable iff (!rst_n_r)
        temp_valid_i ##1 (reg_rd_i && reg_addr_i == `FTS_ADDR_LOCAL_TEMP
            && !temp_valid_i) |=> (reg_rdata_o == $past(temp_local_i, 2));
    endproperty
    a_temp: assert property (p_temp)
        else $error("Local temperature read wrong");

    property p_limit_wr;
        @(posedge sys_clk_i) disable iff (!rst_n_r)
        (reg_wr_i && reg_addr_i == `FTS_ADDR_LOCAL_HIGH)
            ##1 (reg_rd_i && reg_addr_i == `FTS_ADDR_LOCAL_HIGH && !reg_wr_i)
            |=> (reg_rdata_o == $past(reg_wdata_i, 2));
    endproperty
    a_limit_wr: assert property (p_limit_wr)
        else $error("Local high limit write not read back");

    property p_limit_rst;
        @(posedge sys_clk_i)
        $rose(rst_n_r) |-> (local_high_o == `FTS_RST_LOCAL_HIGH);
    endproperty
    a_limit_rst: assert property (p_limit_rst)
        else $error("Local high limit reset value wrong");

    c_lock_pair: cover property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        (reg_rd_i && reg_addr_i == `FTS_ADDR_CNT_LOW)
        ##1 (reg_rd_i && reg_addr_i == `FTS_ADDR_CNT_HIGH));
    c_new_period: cover property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        period_upd && period != `FTS_CNT_FULL);
    c_limit_wr: cover property (@(posedge sys_clk_i) disable iff (!rst_n_r)
        reg_wr_i && reg_addr_i == `FTS_ADDR_LIM_HIGH);

endmodule // fts_top

// ==== tb/fts_fan_model.sv ====
// Behavioural fan that drives the tach pin at a set period
`timescale 1ns/1ps

module fts_fan_model (
    input  wire logic        sys_clk_i,   // Bench clock, paces the pulses
    input  wire logic        run_i,       // Fan spinning
    input  wire logic [15:0] period_i,    // Clocks between rising edges
    output logic             tach_o       // Tach pin
);
    // ------------------------------------------------------------------
    // Pulse train
    // ------------------------------------------------------------------
    // Pin is pulled up, so a stalled fan rests high and makes no edges
    initial tach_o = 1'b1;

    // One low half and one high half per period; the period sets RPM
    // as the host sees it through the count
    always begin
        @(posedge sys_clk_i);
        if (run_i) begin
            #1 tach_o = 1'b0;
            repeat (period_i / 2) @(posedge sys_clk_i);
            #1 tach_o = 1'b1;
            repeat (period_i / 2 - 1) @(posedge sys_clk_i);
        end
    end
endmodule // fts_fan_model

// ==== tb/tb.sv ====
// Self-checking testbench for the fan tach and local temperature block
`timescale 1ns/1ps

module tb;
    // ------------------------------------------------------------------
    // Settings and signals
    // ------------------------------------------------------------------
    localparam int unsigned TB_DIV = 4;    // Short tick keeps runs brief
    localparam int unsigned FAN_P  = 400;  // Fan period in clocks

    logic        sys_clk_i;     // 250 MHz clock
    logic        arst_n_i;      // Async reset, active low
    logic        tach_i;        // From fan model
    logic [1:0]  edge_sel_i;    // Edge-count setting
    logic [7:0]  temp_local_i;  // Die temperature
    logic        temp_valid_i;  // Capture pulse
    logic [7:0]  reg_addr_i;    // Register address
    logic        reg_wr_i;      // Write strobe
    logic [7:0]  reg_wdata_i;   // Write data
    logic        reg_rd_i;      // Read strobe
    logic [7:0]  reg_rdata_o;   // Read data
    logic [7:0]  local_high_o;  // Local high limit
    logic [15:0] tach_limit_o;  // Tach limit
    logic        fan_run;       // Fan spinning
    logic [15:0] fan_period;    // Fan period in clocks
    logic [7:0]  d;             // Read-back byte
    logic [15:0] cnt;           // Assembled count
    int          errors;        // Mismatches
    int          total_checks;  // Comparisons made

    // ------------------------------------------------------------------
    // Clock, design and fan
    // ------------------------------------------------------------------
    initial sys_clk_i = 1'b0;
    always #2 sys_clk_i = ~sys_clk_i;

    fts_top #(.TB_DIV(TB_DIV)) i_fts_top (
        .sys_clk_i    (sys_clk_i),
        .arst_n_i     (arst_n_i),
        .tach_i       (tach_i),
        .edge_sel_i   (edge_sel_i),
        .temp_local_i (temp_local_i),
        .temp_valid_i (temp_valid_i),
        .reg_addr_i   (reg_addr_i),
        .reg_wr_i     (reg_wr_i),
        .reg_wdata_i  (reg_wdata_i),
        .reg_rd_i     (reg_rd_i),
        .reg_rdata_o  (reg_rdata_o),
        .local_high_o (local_high_o),
        .tach_limit_o (tach_limit_o)
    );

    fts_fan_model i_fts_fan_model (
        .sys_clk_i (sys_clk_i),
        .run_i     (fan_run),
        .period_i  (fan_period),
        .tach_o    (tach_i)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Compare and count; X never matches
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // Tick phase against the tach edges blurs the count by a tick
    task automatic check_near(input logic [15:0] got,
                              input logic [15:0] exp);
        if (got >= exp - 16'h0002 && got <= exp + 16'h0002) begin
            check(exp, exp);
        end else begin
            check(got, exp);
        end
    endtask

    // Read: strobe for one edge, data lands one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge sys_clk_i);
        #1 reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge sys_clk_i);
        #1 reg_rd_i = 1'b0;
        q = reg_rdata_o;
    endtask

    // Write: strobe for one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        #1 reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = v;
        @(posedge sys_clk_i);
        #1 reg_wr_i = 1'b0;
    endtask

    // Low byte first so the high byte is locked to it; back to back
    task automatic read_count(output logic [15:0] c);
        logic [7:0] lo;
        logic [7:0] hi;
        @(posedge sys_clk_i);
        #1 reg_rd_i = 1'b1;
        reg_addr_i = 8'h46;
        @(posedge sys_clk_i);
        #1 lo = reg_rdata_o;
        reg_addr_i = 8'h47;
        @(posedge sys_clk_i);
        #1 reg_rd_i = 1'b0;
        hi = reg_rdata_o;
        c = {hi, lo};
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    task automatic test_done(input string name);
        $display("test %s finished", name);
    endtask

    // Single place where the run ends
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Watchdog: all tests need about 86k clocks
    // ------------------------------------------------------------------
    initial begin
        wait_clk(95000);
        errors++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        errors = 0;
        total_checks = 0;
        arst_n_i = 1'b0;
        edge_sel_i = 2'h1;
        temp_local_i = 8'h00;
        temp_valid_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_wdata_i = 8'h00;
        reg_rd_i = 1'b0;
        fan_run = 1'b0;
        fan_period = 16'(FAN_P);
        wait_clk(5);
        #1 arst_n_i = 1'b1;
        // Internal reset needs two edges to clear
        wait_clk(2);

        // Power-on values and unmapped address
        rd(8'h05, d); check(16'(d), 16'h0046);
        check(16'(local_high_o), 16'h0046);
        rd(8'h49, d); check(16'(d), 16'h00FF);
        rd(8'h48, d); check(16'(d), 16'h00FC);
        check(tach_limit_o, 16'hFFFC);
        rd(8'h30, d); check(16'(d), 16'h0000);
        test_done("reset values");

        // Limits writable, temperature read-only
        wr(8'h05, 8'hA5);
        // Read strobed the cycle after the write
        reg_rd_i = 1'b1;
        check(16'(local_high_o), 16'h00A5);
        @(posedge sys_clk_i);
        #1 reg_rd_i = 1'b0;
        check(16'(reg_rdata_o), 16'h00A5);
        wr(8'h48, 8'hFF);
        wr(8'h49, 8'h12);
        rd(8'h48, d); check(16'(d), 16'h00FC);
        check(tach_limit_o, 16'h12FC);
        @(posedge sys_clk_i);
        #1 temp_local_i = 8'h5A;
        temp_valid_i = 1'b1;
        @(posedge sys_clk_i);
        // Read strobed right after the capture pulse
        #1 temp_valid_i = 1'b0;
        reg_rd_i = 1'b1;
        reg_addr_i = 8'h00;
        @(posedge sys_clk_i);
        #1 reg_rd_i = 1'b0;
        check(16'(reg_rdata_o), 16'h005A);
        wr(8'h00, 8'h11);
        rd(8'h00, d); check(16'(d), 16'h005A);
        wr(8'h30, 8'h77);
        rd(8'h30, d); check(16'(d), 16'h0000);
        test_done("registers");

        // Settings 01 and 11 read about 400 counts, setting 10 about 200
        fan_run = 1'b1;
        for (int s = 1; s < 4; s++) begin
            @(posedge sys_clk_i);
            #1 edge_sel_i = s[1:0];
            wr(8'h47, 8'h00);
            wait_clk(10 * FAN_P);
            read_count(cnt);
            check(16'(cnt[1:0]), 16'(s));
            check_near(16'(cnt[15:2]), (s == 2) ? 16'h0032 : 16'h0064);
        end
        test_done("edge settings");

        // Low-byte read locks the high byte across a new measurement
        @(posedge sys_clk_i);
        // Old count about 200 (high 00), new count about 400 (high 01)
        #1 edge_sel_i = 2'h2;
        wait_clk(8 * FAN_P);
        rd(8'h46, d);
        fan_period = 16'(2 * FAN_P);
        wait_clk(8 * FAN_P);
        rd(8'h47, d); check(16'(d), 16'h0000);
        rd(8'h47, d); check(16'(d), 16'h0000);
        read_count(cnt);
        check(16'(cnt[15:8]), 16'h0001);
        check_near(16'(cnt[15:2]), 16'h0064);
        test_done("byte lock");

        // Stalled fan: count pins at full scale, no wrap
        @(posedge sys_clk_i);
        #1 edge_sel_i = 2'h1;
        fan_run = 1'b0;
        // Last edge may come up to a period late; overflow needs 65536
        wait_clk(67000);
        read_count(cnt);
        check(cnt, 16'hFFFD);
        test_done("stall");
        wrap_up();
    end
endmodule // tb
